// ==== stream_test_generator.sv ====
// Sequential 4 KB command, address and pattern generator with AXI4-Lite control
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps

module stream_test_generator #(
	parameter int ADDR_W = stream_test_pkg::ADDR_W,
	parameter int DATA_W = stream_test_pkg::DATA_W
) (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic [stream_test_pkg::AXI_AW-1:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [stream_test_pkg::AXI_AW-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic O_CMD_REQ_VALID,
	input wire logic I_CMD_REQ_READY,
	output logic [ADDR_W-1:0] O_CMD_ADDRESS,
	input wire logic I_HOST_CTRL_BUSY,
	output logic [DATA_W-1:0] O_WRITE_DATA_BUS,
	output logic O_WRITE_DATA_VALID,
	input wire logic I_WRITE_DATA_READY,
	input wire logic [DATA_W-1:0] I_READ_DATA_BUS,
	input wire logic I_READ_DATA_VALID,
	output logic O_GENERATOR_BUSY
);

	// ==========================================================
	// Elaboration checks
	if (ADDR_W != 48 || DATA_W != 128) begin : g_bad_width
		$error("stream_test_generator supports only 48-bit address and 128-bit data");
	end

	// ==========================================================
	// Helper functions
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'h0) && (a <= stream_test_pkg::REG_FAIL_RCV);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		merge = r;
	endfunction

	// Wrap past maximum; step is one 4KB unit
	function automatic logic [47:0] next_addr(input logic [47:0] a, input logic [47:0] mx);
		next_addr = (a >= mx) ? 48'h0000_0000_0000 : a + stream_test_pkg::UNIT_ADDR_STEP;
	endfunction

	function automatic logic [31:0] lfsr_step(input logic [31:0] x);
		lfsr_step = {x[30:0], x[30] ^ x[20] ^ x[0]};
	endfunction

	// Look-ahead: state after four values in one clock
	function automatic logic [31:0] lfsr_adv4(input logic [31:0] x);
		lfsr_adv4 = lfsr_step(lfsr_step(lfsr_step(lfsr_step(x))));
	endfunction

	// Unit seed never zero, so the LFSR cannot lock up
	function automatic logic [31:0] lfsr_cur(input logic [7:0] beat, input logic [47:0] hdr, input logic [31:0] st);
		lfsr_cur = (beat == 8'h00) ? {hdr[31:1], 1'b1} : st;
	endfunction

	// One 128-bit beat of a unit, dword 0 in the low bits
	function automatic logic [127:0] gen_beat(input logic [2:0] sel, input logic [47:0] hdr, input logic [7:0] beat,
			input logic [31:0] lf);
		logic [127:0] w;
		logic [31:0] inc;
		logic [31:0] lv;
		lv = lf;
		w = '0;
		for (int i = 0; i < 4; i++) begin
			inc = {hdr[21:0], beat, i[1:0]};
			unique case (sel)
				stream_test_pkg::PATT_DEC: w[i*32 +: 32] = ~inc;
				stream_test_pkg::PATT_LFSR: w[i*32 +: 32] = lv;
				stream_test_pkg::PATT_ZERO: w[i*32 +: 32] = 32'h0000_0000;
				stream_test_pkg::PATT_ONE: w[i*32 +: 32] = 32'hFFFF_FFFF;
				default: w[i*32 +: 32] = inc;
			endcase
			lv = lfsr_step(lv);
		end
		// Header in dwords 0 and 1; none for zero/one fill
		if (beat == 8'h00 && sel != stream_test_pkg::PATT_ZERO && sel != stream_test_pkg::PATT_ONE) begin
			w[63:0] = {16'h0000, hdr};
		end
		gen_beat = w;
	endfunction

	// ==========================================================
	// Declarations
	stream_test_pkg::gen_state_t state_q, state_d;
	logic [7:0] awaddr_q, wr_beat_q, rd_beat_q;
	logic [31:0] wdata_q, start_lo_q, start_hi_q, max_lo_q, max_hi_q, size_q, comp_q;
	logic [31:0] fail_no_q, fail_exp_q, fail_rcv_q, rd_mux, wr_lfsr_q, rd_lfsr_q, exp_dw, rcv_dw;
	logic [3:0] wstrb_q;
	logic [2:0] pattern_q, ctrl_pulse_q;
	logic wr_fire, is_write_q, stop_latch_q, fail_q, wr_issue, rd_issue, rd_unit_done, mismatch;
	logic [47:0] cur_addr_q, wr_hdr_q, rd_hdr_q, max_addr, start_addr;
	logic [127:0] exp_beat;
	logic [31:0] wr_lf, rd_lf;

	assign max_addr = {max_hi_q[15:0], max_lo_q};
	assign start_addr = {start_hi_q[15:0], start_lo_q};
	assign wr_fire = !O_AWREADY && !O_WREADY && !O_BVALID;

	// ==========================================================
	// AXI4-Lite write channels: address and data in either order
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_AWREADY <= 1'b1;
			O_WREADY <= 1'b1;
			O_BVALID <= 1'b0;
			O_BRESP <= stream_test_pkg::RESP_OKAY;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (I_AWVALID && O_AWREADY) begin
				awaddr_q <= I_AWADDR;
				O_AWREADY <= 1'b0;
			end
			if (I_WVALID && O_WREADY) begin
				wdata_q <= I_WDATA;
				wstrb_q <= I_WSTRB;
				O_WREADY <= 1'b0;
			end
			if (wr_fire) begin
				O_BVALID <= 1'b1;
				O_BRESP <= is_mapped(awaddr_q) ? stream_test_pkg::RESP_OKAY : stream_test_pkg::RESP_SLVERR;
			end
			if (O_BVALID && I_BREADY) begin
				O_BVALID <= 1'b0;
				O_AWREADY <= 1'b1;
				O_WREADY <= 1'b1;
			end
		end
	end

	// Software registers; control bits become one-cycle pulses
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ctrl_pulse_q <= 3'h0;
			pattern_q <= stream_test_pkg::PATT_INC;
			start_lo_q <= 32'h0000_0000;
			start_hi_q <= 32'h0000_0000;
			max_lo_q <= stream_test_pkg::MAX_ADDR_RESET[31:0];
			max_hi_q <= {16'h0000, stream_test_pkg::MAX_ADDR_RESET[47:32]};
		end else begin
			ctrl_pulse_q <= 3'h0;
			if (wr_fire) begin
				unique case (awaddr_q)
					stream_test_pkg::REG_CTRL: ctrl_pulse_q <= wstrb_q[0] ? wdata_q[2:0] : 3'h0;
					stream_test_pkg::REG_PATTERN: pattern_q <= wstrb_q[0] ? wdata_q[2:0] : pattern_q;
					stream_test_pkg::REG_START_LO: start_lo_q <= merge(start_lo_q, wdata_q, wstrb_q);
					stream_test_pkg::REG_START_HI: start_hi_q <= merge(start_hi_q, wdata_q, wstrb_q) & 32'h0000_FFFF;
					stream_test_pkg::REG_MAX_LO: max_lo_q <= merge(max_lo_q, wdata_q, wstrb_q);
					stream_test_pkg::REG_MAX_HI: max_hi_q <= merge(max_hi_q, wdata_q, wstrb_q) & 32'h0000_FFFF;
					default: ;
				endcase
			end
		end
	end

	// Read data mux; unmapped and reserved bits read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (I_ARADDR)
			stream_test_pkg::REG_PATTERN: rd_mux = {29'h0000_0000, pattern_q};
			stream_test_pkg::REG_START_LO: rd_mux = start_lo_q;
			stream_test_pkg::REG_START_HI: rd_mux = start_hi_q;
			stream_test_pkg::REG_MAX_LO: rd_mux = max_lo_q;
			stream_test_pkg::REG_MAX_HI: rd_mux = max_hi_q;
			stream_test_pkg::REG_STATUS: begin
				rd_mux[stream_test_pkg::STAT_BUSY] = O_GENERATOR_BUSY;
				rd_mux[stream_test_pkg::STAT_FAIL] = fail_q;
				rd_mux[stream_test_pkg::STAT_STOP] = stop_latch_q;
				rd_mux[stream_test_pkg::STAT_STATE +: 3] = state_q;
			end
			stream_test_pkg::REG_SIZE: rd_mux = size_q;
			stream_test_pkg::REG_COMP: rd_mux = comp_q;
			stream_test_pkg::REG_FAIL_NO: rd_mux = fail_no_q;
			stream_test_pkg::REG_FAIL_EXP: rd_mux = fail_exp_q;
			stream_test_pkg::REG_FAIL_RCV: rd_mux = fail_rcv_q;
			default: ;
		endcase
	end

	// AXI4-Lite read channel, answer one cycle after the address
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_ARREADY <= 1'b1;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0000_0000;
			O_RRESP <= stream_test_pkg::RESP_OKAY;
		end else if (I_ARVALID && O_ARREADY) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b1;
			O_RDATA <= rd_mux;
			O_RRESP <= is_mapped(I_ARADDR) ? stream_test_pkg::RESP_OKAY : stream_test_pkg::RESP_SLVERR;
		end else if (O_RVALID && I_RREADY) begin
			O_RVALID <= 1'b0;
			O_ARREADY <= 1'b1;
		end
	end

	// ==========================================================
	// Command state machine
	assign wr_issue = (state_q == stream_test_pkg::STATE_WRITE_COMMAND) && I_CMD_REQ_READY;
	assign rd_issue = (state_q == stream_test_pkg::STATE_READ_ISSUE) && !stop_latch_q && I_CMD_REQ_READY;

	// Seven states: idle, init, write wait/data/command, read issue, drain
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			stream_test_pkg::STATE_IDLE: begin
				if (ctrl_pulse_q[stream_test_pkg::CTRL_WR_START] || ctrl_pulse_q[stream_test_pkg::CTRL_RD_START]) begin
					state_d = stream_test_pkg::STATE_INIT;
				end
			end
			stream_test_pkg::STATE_INIT: state_d = is_write_q ? stream_test_pkg::STATE_WRITE_WAIT
				: stream_test_pkg::STATE_READ_ISSUE;
			stream_test_pkg::STATE_WRITE_WAIT: begin
				// Stop has priority over new data
				if (stop_latch_q) begin
					state_d = stream_test_pkg::STATE_DRAIN;
				end else if (I_WRITE_DATA_READY) begin
					state_d = stream_test_pkg::STATE_WRITE_DATA;
				end
			end
			stream_test_pkg::STATE_WRITE_DATA: begin
				// Leave after beat 255 was sent
				if (wr_beat_q == 8'h00) begin
					state_d = stream_test_pkg::STATE_WRITE_COMMAND;
				end
			end
			stream_test_pkg::STATE_WRITE_COMMAND: if (I_CMD_REQ_READY) state_d = stream_test_pkg::STATE_WRITE_WAIT;
			// Stop seen here ends read issue
			stream_test_pkg::STATE_READ_ISSUE: if (stop_latch_q) state_d = stream_test_pkg::STATE_DRAIN;
			// Wait for controller to finish its queue
			stream_test_pkg::STATE_DRAIN: if (!I_HOST_CTRL_BUSY) state_d = stream_test_pkg::STATE_IDLE;
			default: state_d = stream_test_pkg::STATE_IDLE;
		endcase
	end

	// Reset lands in idle with the latch clear
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			state_q <= stream_test_pkg::STATE_IDLE;
			is_write_q <= 1'b0;
			stop_latch_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == stream_test_pkg::STATE_IDLE) begin
				is_write_q <= ctrl_pulse_q[stream_test_pkg::CTRL_WR_START];
			end
			// Stop pulse held until drain starts; a new pulse wins
			// A stop during drain is dropped so it cannot end the next run at once
			if (ctrl_pulse_q[stream_test_pkg::CTRL_STOP] && state_q != stream_test_pkg::STATE_IDLE
					&& state_q != stream_test_pkg::STATE_DRAIN) begin
				stop_latch_q <= 1'b1;
			end else if (state_d == stream_test_pkg::STATE_DRAIN) begin
				stop_latch_q <= 1'b0;
			end
		end
	end

	// Busy flag low only in idle
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_GENERATOR_BUSY <= 1'b0;
		end else begin
			O_GENERATOR_BUSY <= (state_d != stream_test_pkg::STATE_IDLE);
		end
	end

	// ==========================================================
	// Command request and address counter
	// Valid is a one-cycle pulse with its address
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_CMD_REQ_VALID <= 1'b0;
			O_CMD_ADDRESS <= '0;
			cur_addr_q <= '0;
		end else begin
			O_CMD_REQ_VALID <= wr_issue || rd_issue;
			if (state_q == stream_test_pkg::STATE_INIT) begin
				// Counter starts at the user address
				cur_addr_q <= start_addr;
			end else if (wr_issue || rd_issue) begin
				O_CMD_ADDRESS <= cur_addr_q;
				cur_addr_q <= next_addr(cur_addr_q, max_addr);
			end
		end
	end

	// ==========================================================
	// Write data generator
	assign wr_lf = lfsr_cur(wr_beat_q, wr_hdr_q, wr_lfsr_q);

	// Full unit of data goes out before its command
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_WRITE_DATA_VALID <= 1'b0;
			O_WRITE_DATA_BUS <= '0;
			wr_beat_q <= 8'h00;
			wr_hdr_q <= '0;
			wr_lfsr_q <= 32'h0000_0001;
		end else begin
			O_WRITE_DATA_VALID <= (state_d == stream_test_pkg::STATE_WRITE_DATA);
			if (state_q == stream_test_pkg::STATE_INIT) begin
				wr_beat_q <= 8'h00;
				wr_hdr_q <= start_addr;
			end else if (state_d == stream_test_pkg::STATE_WRITE_DATA) begin
				// New word each of the 256 cycles
				O_WRITE_DATA_BUS <= gen_beat(pattern_q, wr_hdr_q, wr_beat_q, wr_lf);
				wr_beat_q <= wr_beat_q + 8'h01;
				wr_lfsr_q <= lfsr_adv4(wr_lf);
				// Header counter steps after each unit
				if (wr_beat_q == stream_test_pkg::LAST_BEAT) begin
					wr_hdr_q <= next_addr(wr_hdr_q, max_addr);
				end
			end
		end
	end

	// ==========================================================
	// Read data checker
	assign rd_lf = lfsr_cur(rd_beat_q, rd_hdr_q, rd_lfsr_q);
	assign exp_beat = gen_beat(pattern_q, rd_hdr_q, rd_beat_q, rd_lf);
	assign rd_unit_done = I_READ_DATA_VALID && (rd_beat_q == stream_test_pkg::LAST_BEAT);

	// Lowest mismatching dword is the one reported
	always_comb begin
		mismatch = 1'b0;
		exp_dw = 32'h0000_0000;
		rcv_dw = 32'h0000_0000;
		for (int i = 3; i >= 0; i--) begin
			if (exp_beat[i*32 +: 32] != I_READ_DATA_BUS[i*32 +: 32]) begin
				mismatch = 1'b1;
				exp_dw = exp_beat[i*32 +: 32];
				rcv_dw = I_READ_DATA_BUS[i*32 +: 32];
			end
		end
	end

	// Returned beats counted independently of command issue
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			rd_beat_q <= 8'h00;
			rd_hdr_q <= '0;
			rd_lfsr_q <= 32'h0000_0001;
		end else if (state_q == stream_test_pkg::STATE_INIT) begin
			rd_beat_q <= 8'h00;
			rd_hdr_q <= start_addr;
		end else if (I_READ_DATA_VALID) begin
			rd_beat_q <= rd_beat_q + 8'h01;
			rd_lfsr_q <= lfsr_adv4(rd_lf);
			if (rd_unit_done) begin
				rd_hdr_q <= next_addr(rd_hdr_q, max_addr);
			end
		end
	end

	// First failure latched; init clears the fail flag only
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			fail_q <= 1'b0;
			fail_no_q <= 32'h0000_0000;
			fail_exp_q <= 32'h0000_0000;
			fail_rcv_q <= 32'h0000_0000;
		end else if (state_q == stream_test_pkg::STATE_INIT) begin
			fail_q <= 1'b0;
		end else if (I_READ_DATA_VALID && !is_write_q && mismatch && !fail_q) begin
			fail_q <= 1'b1;
			fail_no_q <= size_q;
			fail_exp_q <= exp_dw;
			fail_rcv_q <= rcv_dw;
		end
	end

	// ==========================================================
	// Progress counters
	// Size in beats; write commands issued plus read units returned
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			size_q <= 32'h0000_0000;
			comp_q <= 32'h0000_0000;
		end else if (state_q == stream_test_pkg::STATE_INIT) begin
			size_q <= 32'h0000_0000;
			comp_q <= 32'h0000_0000;
		end else begin
			size_q <= size_q + {31'h0000_0000, O_WRITE_DATA_VALID} + {31'h0000_0000, I_READ_DATA_VALID};
			comp_q <= comp_q + {31'h0000_0000, wr_issue} + {31'h0000_0000, rd_unit_done};
		end
	end

endmodule // stream_test_generator

// ==== stream_test_pkg.sv ====
// Constants, register map and state codes shared by the stream test generator
package stream_test_pkg;

	// ==========================================================
	// Widths and sizes
	localparam int ADDR_W = 48;
	localparam int DATA_W = 128;
	localparam int BEATS_PER_UNIT = 256;
	localparam int BEAT_W = 8;
	localparam int AXI_AW = 8;
	localparam logic [47:0] UNIT_ADDR_STEP = 48'h0000_0000_0008;
	localparam logic [47:0] MAX_ADDR_RESET = 48'hFFFF_FFFF_FFF8;
	localparam logic [7:0] LAST_BEAT = 8'hFF;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PATTERN = 8'h04;
	localparam logic [7:0] REG_START_LO = 8'h08;
	localparam logic [7:0] REG_START_HI = 8'h0C;
	localparam logic [7:0] REG_MAX_LO = 8'h10;
	localparam logic [7:0] REG_MAX_HI = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_SIZE = 8'h1C;
	localparam logic [7:0] REG_COMP = 8'h20;
	localparam logic [7:0] REG_FAIL_NO = 8'h24;
	localparam logic [7:0] REG_FAIL_EXP = 8'h28;
	localparam logic [7:0] REG_FAIL_RCV = 8'h2C;

	// ==========================================================
	// Field positions
	localparam int CTRL_WR_START = 0;
	localparam int CTRL_RD_START = 1;
	localparam int CTRL_STOP = 2;
	localparam int STAT_BUSY = 0;
	localparam int STAT_FAIL = 1;
	localparam int STAT_STOP = 2;
	localparam int STAT_STATE = 4;

	// ==========================================================
	// Bus answers and pattern codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] PATT_INC = 3'h0;
	localparam logic [2:0] PATT_DEC = 3'h1;
	localparam logic [2:0] PATT_LFSR = 3'h2;
	localparam logic [2:0] PATT_ZERO = 3'h3;
	localparam logic [2:0] PATT_ONE = 3'h4;

	// ==========================================================
	// Command state machine
	typedef enum logic [2:0] {
		STATE_IDLE = 3'b000,
		STATE_INIT = 3'b001,
		STATE_WRITE_WAIT = 3'b010,
		STATE_WRITE_DATA = 3'b011,
		STATE_WRITE_COMMAND = 3'b100,
		STATE_READ_ISSUE = 3'b101,
		STATE_DRAIN = 3'b110
	} gen_state_t;

endpackage

// ==== stream_test_props.sv ====
// Concurrent checks on the command and write data ports of the stream test generator
`timescale 1ns/10ps
module stream_test_props (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic O_CMD_REQ_VALID,
	input wire logic I_CMD_REQ_READY,
	input wire logic [47:0] O_CMD_ADDRESS,
	input wire logic I_HOST_CTRL_BUSY,
	input wire logic O_WRITE_DATA_VALID,
	input wire logic I_WRITE_DATA_READY,
	input wire logic O_GENERATOR_BUSY
);
	// ==========================================================
	// Helper state
	logic [8:0] run_q;
	logic [47:0] last_q;
	logic seen_q;
	// Length of the current unbroken run of write beats
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			run_q <= 9'h000;
		end else begin
			run_q <= O_WRITE_DATA_VALID ? run_q + 9'h001 : 9'h000;
		end
	end
	// Last address sent; forgotten in idle so a new start may jump
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			seen_q <= 1'b0;
			last_q <= 48'h0000_0000_0000;
		end else if (!O_GENERATOR_BUSY) begin
			seen_q <= 1'b0;
		end else if (O_CMD_REQ_VALID) begin
			seen_q <= 1'b1;
			last_q <= O_CMD_ADDRESS;
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	sequence s_unit_done;
		$fell(O_WRITE_DATA_VALID);
	endsequence
	property p_reset_quiet;
		disable iff (1'b0) I_RST |-> !O_CMD_REQ_VALID && !O_WRITE_DATA_VALID && !O_GENERATOR_BUSY;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
	property p_idle_silent;
		!O_GENERATOR_BUSY |-> !O_CMD_REQ_VALID && !O_WRITE_DATA_VALID;
	endproperty
	a_idle_silent: assert property (p_idle_silent) else $error("request while not busy");
	property p_unit_len;
		s_unit_done |-> run_q == 9'h100;
	endproperty
	a_unit_len: assert property (p_unit_len) else $error("write unit not 256 beats");
	property p_unit_max;
		O_WRITE_DATA_VALID |-> run_q < 9'h100;
	endproperty
	a_unit_max: assert property (p_unit_max) else $error("write unit too long");
	property p_wcmd_follow;
		s_unit_done |-> ##[0:1000] O_CMD_REQ_VALID;
	endproperty
	a_wcmd_follow: assert property (p_wcmd_follow) else $error("no command after unit");
	property p_cmd_ready;
		O_CMD_REQ_VALID |-> $past(I_CMD_REQ_READY);
	endproperty
	a_cmd_ready: assert property (p_cmd_ready) else $error("command without ready");
	property p_addr_step;
		O_CMD_REQ_VALID && seen_q |-> O_CMD_ADDRESS == last_q + 48'h0000_0000_0008 || O_CMD_ADDRESS == 48'h0;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("address not sequential");
	property p_wdata_start;
		$rose(O_WRITE_DATA_VALID) |-> $past(I_WRITE_DATA_READY);
	endproperty
	a_wdata_start: assert property (p_wdata_start) else $error("beats without ready");
	property p_drain_exit;
		$fell(O_GENERATOR_BUSY) |-> !$past(I_HOST_CTRL_BUSY);
	endproperty
	a_drain_exit: assert property (p_drain_exit) else $error("idle while host busy");
endmodule // stream_test_props

bind stream_test_generator stream_test_props chk_u (.I_CLK, .I_RST, .O_CMD_REQ_VALID, .I_CMD_REQ_READY,
	.O_CMD_ADDRESS, .I_HOST_CTRL_BUSY, .O_WRITE_DATA_VALID, .I_WRITE_DATA_READY, .O_GENERATOR_BUSY);

// ==== host_ctrl_model.sv ====
// Behavioural host controller stand-in: command queue, busy and read returns
`timescale 1ns/10ps
module host_ctrl_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic rd_mode,
	input wire logic cmd_valid,
	input wire logic [47:0] cmd_addr,
	output logic cmd_ready,
	output logic busy,
	output logic wr_ready,
	output logic rd_valid,
	output logic [127:0] rd_data
);
	logic [47:0] q[$];
	logic [127:0] nd;
	int outst;
	int bt;
	int i;
	bit fire;
	// Random stalls on every channel; idle read data toggles so stale beats never look valid
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			outst = 0;
			bt = 0;
			q.delete();
			{cmd_ready, busy, wr_ready, rd_valid} <= 4'h0;
			rd_data <= '0;
		end else begin
			nd = ~rd_data;
			fire = 1'b0;
			if (cmd_valid) begin
				outst++;
				if (rd_mode) q.push_back(cmd_addr);
			end
			if (q.size() != 0 && $urandom_range(7) != 0) begin
				for (i = 0; i < 4; i++) nd[i*32 +: 32] = {q[0][21:0], bt[7:0], i[1:0]};
				if (bt == 0) nd[63:0] = {16'h0000, q[0]};
				fire = 1'b1;
				bt++;
				if (bt == 256) begin
					bt = 0;
					void'(q.pop_front());
					outst--;
				end
			end else if (!rd_mode && outst != 0 && $urandom_range(3) == 0) begin
				outst--;
			end
			// Valid only on cycles that really carry a beat, never on a stall
			rd_valid <= fire;
			rd_data <= nd;
			cmd_ready <= (outst < 28) && ($urandom_range(3) != 0);
			wr_ready <= $urandom_range(1);
			busy <= (outst != 0);
		end
	end
endmodule // host_ctrl_model

// ==== tb_top.sv ====
// Self-checking bench for the stream test generator against the controller model
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0, rst = 1'b0, rd_mode = 1'b0;
	logic [2:0] patt = 3'h0;
	logic [31:0] lf = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, beat = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awready, wready, bvalid, arready, rvalid, cmd_valid, cmd_ready, busy, wd_valid, wr_ready, rd_valid, gbusy;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [47:0] cmd_addr, a0;
	logic [127:0] wd_bus, rd_data;
	logic [63:0] exp_q[$];
	logic [47:0] addr_q[$];
	int n_mismatch = 0, comparisons = 0, n_cmd = 0, cyc = 0;
	stream_test_generator dut_u (.I_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
		.O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
		.O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
		.O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
		.O_CMD_REQ_VALID(cmd_valid), .I_CMD_REQ_READY(cmd_ready), .O_CMD_ADDRESS(cmd_addr),
		.I_HOST_CTRL_BUSY(busy), .O_WRITE_DATA_BUS(wd_bus), .O_WRITE_DATA_VALID(wd_valid),
		.I_WRITE_DATA_READY(wr_ready), .I_READ_DATA_BUS(rd_data), .I_READ_DATA_VALID(rd_valid),
		.O_GENERATOR_BUSY(gbusy));
	host_ctrl_model far_u (.clk, .rst, .rd_mode, .cmd_valid, .cmd_addr, .cmd_ready, .busy, .wr_ready,
		.rd_valid, .rd_data);
	initial begin
		forever #4 clk = ~clk;
	end
	// ==========================================================
	// Checking and closing
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Expected write words from the pattern rules
	function automatic logic [31:0] lstep(input logic [31:0] x, input int n);
		for (int k = 0; k < n; k++) begin
			x = {x[30:0], x[30] ^ x[20] ^ x[0]};
		end
		return x;
	endfunction
	function automatic logic [63:0] hdr_exp(input logic [2:0] p, input logic [47:0] h);
		return (p == stream_test_pkg::PATT_ZERO) ? 64'h0000_0000_0000_0000 : (p == stream_test_pkg::PATT_ONE)
			? 64'hFFFF_FFFF_FFFF_FFFF : {16'h0000, h};
	endfunction
	function automatic logic [31:0] dw3_exp(input logic [2:0] p, input logic [47:0] h, input logic [7:0] b,
			input logic [31:0] l);
		return (p == stream_test_pkg::PATT_ZERO) ? 32'h0000_0000 : (p == stream_test_pkg::PATT_ONE) ? 32'hFFFF_FFFF
			: (p == stream_test_pkg::PATT_LFSR) ? l : {h[21:0], b, 2'h3} ^ {32{p == stream_test_pkg::PATT_DEC}};
	endfunction
	// Hang guard well above all runs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			results();
		end
	end
	// Oldest note against each answer, command and write beat
	always @(posedge clk) begin
		if (rvalid === 1'b1 && rready === 1'b1) cmp({30'h0, rresp, rdata}, exp_q.pop_front());
		if (cmd_valid === 1'b1) begin
			n_cmd++;
			cmp(64'(cmd_addr), 64'(addr_q.pop_front()));
		end
		if (wd_valid === 1'b1) begin
			if (beat == 8'h00) lf = {addr_q[0][31:1], 1'b1};
			if (beat == 8'h00) cmp(wd_bus[63:0], hdr_exp(patt, addr_q[0]));
			cmp(64'(wd_bus[127:96]), 64'(dw3_exp(patt, addr_q[0], beat, lstep(lf, 3))));
			lf = lstep(lf, 4);
			beat <= beat + 8'h01;
		end
	end
	// ==========================================================
	// Bus tasks: hold every channel until its own handshake edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (awvalid || wvalid);
		while (bvalid !== 1'b1) @(posedge clk);
		cmp(64'(bresp), 64'(r));
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [63:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		{araddr, arvalid, rready} <= {a, 2'h3};
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	// One start to stop run; the expected address list follows the wrap rule
	task automatic run(input logic [2:0] p, input logic [47:0] m, input int n, input int sb, input logic [63:0] st);
		logic [47:0] a;
		int i;
		a = a0;
		addr_q.delete();
		for (i = 0; i < 64; i++) begin
			addr_q.push_back(a);
			a = (a >= m) ? 48'h0000_0000_0000 : a + 48'h0000_0000_0008;
		end
		patt = p;
		rd_mode <= (sb == stream_test_pkg::CTRL_RD_START);
		n_cmd = 0;
		axi_wr(stream_test_pkg::REG_PATTERN, 32'(p), 2'h0);
		axi_wr(stream_test_pkg::REG_START_LO, a0[31:0], 2'h0);
		axi_wr(stream_test_pkg::REG_START_HI, 32'(a0[47:32]), 2'h0);
		axi_wr(stream_test_pkg::REG_MAX_LO, m[31:0], 2'h0);
		axi_wr(stream_test_pkg::REG_MAX_HI, 32'(m[47:32]), 2'h0);
		axi_wr(stream_test_pkg::REG_CTRL, 32'h0000_0001 << sb, 2'h0);
		for (i = 0; i < 5000 && n_cmd < n; i++) @(posedge clk);
		cmp(64'(n_cmd >= n), 64'h0000_0000_0000_0001);
		axi_wr(stream_test_pkg::REG_CTRL, 32'h0000_0004, 2'h0);
		for (i = 0; i < 20000 && gbusy !== 1'b0; i++) @(posedge clk);
		axi_rd(stream_test_pkg::REG_STATUS, st);
		axi_rd(stream_test_pkg::REG_COMP, 64'(n_cmd));
		axi_rd(stream_test_pkg::REG_SIZE, 64'(n_cmd * 256));
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(47));
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		axi_rd(stream_test_pkg::REG_STATUS, 64'h0);
		axi_rd(stream_test_pkg::REG_MAX_LO, 64'hFFFF_FFF8);
		axi_rd(8'h30, {30'h0, stream_test_pkg::RESP_SLVERR, 32'h0000_0000});
		axi_wr(8'h30, 32'h0000_0000, stream_test_pkg::RESP_SLVERR);
		a0 = {16'h0000, $urandom & 32'h0FFF_FFF8};
		// Write units back to back with decrementing data
		run(stream_test_pkg::PATT_DEC, 48'hFFFF_FFFF_FFF8, 3, stream_test_pkg::CTRL_WR_START, 64'h0);
		// Reads wrap to zero two commands after the start
		run(stream_test_pkg::PATT_INC, a0 + 48'h0000_0000_0008, 6, stream_test_pkg::CTRL_RD_START, 64'h0);
		// Decrementing expectation against incrementing returns fails first at dword 2 of beat 0
		run(stream_test_pkg::PATT_DEC, 48'hFFFF_FFFF_FFF8, 2, stream_test_pkg::CTRL_RD_START, 64'h2);
		axi_rd(stream_test_pkg::REG_FAIL_NO, 64'h0);
		axi_rd(stream_test_pkg::REG_FAIL_EXP, {32'h0000_0000, ~{a0[21:0], 8'h00, 2'h2}});
		axi_rd(stream_test_pkg::REG_FAIL_RCV, {32'h0000_0000, a0[21:0], 8'h00, 2'h2});
		run(stream_test_pkg::PATT_ONE, 48'hFFFF_FFFF_FFF8, 1, stream_test_pkg::CTRL_WR_START, 64'h0);
		run(stream_test_pkg::PATT_LFSR, 48'hFFFF_FFFF_FFF8, 1, stream_test_pkg::CTRL_WR_START, 64'h0);
		results();
	end
endmodule // tb_top
